/* rtl/adc_seq_pkg.sv */
// Constants, channel codes and range tables for the measurement sequencer.
// Assumes a 125 MHz core clock; all slower rates come from enable pulses.
package adc_seq_pkg;
    // Clock rates in kHz
    localparam int CLK_KHZ = 125000;
    localparam int SYS_OSC_KHZ = 4000;
    localparam int BOOST_OSC_SLOW_KHZ = 11500;
    localparam int BOOST_OSC_FAST_KHZ = 22000;
    localparam int PWM_PERIOD_CYC = 64;
    localparam int PWM_CNT_W = $clog2(PWM_PERIOD_CYC);

    // Converter slot: mux settle then eight bit decisions, in system ticks
    localparam int SLOT_NS = 3000;
    localparam int SLOT_TICKS = SLOT_NS * SYS_OSC_KHZ / 1000000;
    localparam int SETTLE_NS = 500;
    localparam int SETTLE_TICKS = (SETTLE_NS * SYS_OSC_KHZ + 999999) / 1000000;
    localparam int TICK_CNT_W = 4;

    // Slow auxiliary refresh, in system ticks
    localparam int AUX_PERIOD_US = 4000;
    localparam int AUX_PERIOD_TICKS = AUX_PERIOD_US * SYS_OSC_KHZ / 1000;

    // Odd-slot schedule: 18 odd slots, one every 6 us, make 108 us
    localparam int ODD_SEQ_LEN = 18;
    localparam logic [4:0] POS_BATT = 5'h00;
    localparam logic [4:0] POS_LED1_A = 5'h04;
    localparam logic [4:0] POS_LED1_B = 5'h0D;
    localparam logic [4:0] POS_LED2_A = 5'h08;
    localparam logic [4:0] POS_LED2_B = 5'h11;

    localparam int RES_W = 8;
    localparam int CH_NUM = 6;
    localparam logic [RES_W-1:0] RESULT_RST = 8'h00;
    localparam logic [RES_W-1:0] SAR_MSB = 8'h80;

    typedef enum logic [2:0] {
        CH_BOOST = 3'b000,
        CH_BATT = 3'b001,
        CH_LED1 = 3'b010,
        CH_LED2 = 3'b011,
        CH_AUX1 = 3'b100,
        CH_AUX2 = 3'b101
    } channel_t;

    // Full-scale voltage of code 255 per channel, in mV
    // boost 80 V full scale
    localparam int FS_BOOST_MV = 80000;
    localparam int FS_BATT_MV = 40000;
    localparam int FS_LED_MV = 80000;
    // aux inputs 3 V full scale
    localparam int FS_AUX_MV = 3000;

    // Boost range tables, codes in boost-channel steps
    localparam logic [7:0] TRGT_BASE_CODE = 8'h30;
    localparam logic [7:0] TRGT_STEP_CODE = 8'h08;
    localparam logic [7:0] WIN_HALF_CODE = 8'h10;
    localparam logic [7:0] SD_MARGIN_CODE = 8'h18;

    function automatic logic [7:0] range_target(input logic [3:0] rng);
        range_target = TRGT_BASE_CODE + 8'({4'h0, rng} * TRGT_STEP_CODE);
    endfunction
endpackage

/* rtl/sar_converter.sv */
// Successive-approximation register for one 8-bit conversion.
// Assumes an external DAC and comparator: comp_ge high when input >= dac_code.
`timescale 1ns/1ps
`default_nettype none
module sar_converter (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic step_en,
    input wire logic comp_ge,
    output logic [adc_seq_pkg::RES_W-1:0] dac_code,
    output logic [adc_seq_pkg::RES_W-1:0] result,
    output logic busy,
    output logic done
);
    logic [adc_seq_pkg::RES_W-1:0] code_q;
    logic [adc_seq_pkg::RES_W-1:0] code_d;
    logic [adc_seq_pkg::RES_W-1:0] trial_q;
    logic [adc_seq_pkg::RES_W-1:0] kept;
    logic busy_q;
    logic last;

    // Keep or drop the bit under trial, then try the next lower one
    assign kept = comp_ge ? code_q : (code_q & ~trial_q);
    assign last = trial_q[0];
    assign code_d = last ? kept : (kept | (trial_q >> 1));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= adc_seq_pkg::RESULT_RST;
            trial_q <= adc_seq_pkg::RESULT_RST;
            busy_q <= 1'b0;
            done <= 1'b0;
            result <= adc_seq_pkg::RESULT_RST;
        end else begin
            done <= 1'b0;
            if (start) begin
                code_q <= adc_seq_pkg::SAR_MSB;
                trial_q <= adc_seq_pkg::SAR_MSB;
                busy_q <= 1'b1;
            end else if (busy_q && step_en) begin
                code_q <= code_d;
                trial_q <= trial_q >> 1;
                if (last) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                    result <= kept;
                end
            end
        end
    end

    assign dac_code = code_q;
    assign busy = busy_q;
endmodule
`default_nettype wire

/* rtl/adc_measurement_sequencer.sv */
// Autonomous measurement sequencer around one shared 8-bit SAR converter,
// with result memory, host readout, system and booster reference timing,
// boost range tables and the shutdown gate cut-off.
// Assumes the analog mux, DAC and comparator sit outside, and that the
// serial-interface logic presents the select pointer and range as levels.
`timescale 1ns/1ps
`default_nettype none
module adc_measurement_sequencer #(
    parameter int AUX_PERIOD_TICKS = adc_seq_pkg::AUX_PERIOD_TICKS
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic comp_ge,
    input wire logic string1_active,
    input wire logic string2_active,
    input wire logic [2:0] measurement_select,
    input wire logic [3:0] boost_range,
    input wire logic booster_osc_fast,
    input wire logic [adc_seq_pkg::PWM_CNT_W-1:0] boost_duty,
    output logic [2:0] mux_select,
    output logic [adc_seq_pkg::RES_W-1:0] dac_code,
    output logic [adc_seq_pkg::RES_W-1:0] measurement_readout_register,
    output logic [adc_seq_pkg::RES_W-1:0] boost_result,
    output logic [adc_seq_pkg::RES_W-1:0] battery_result,
    output logic [adc_seq_pkg::RES_W-1:0] string1_result,
    output logic [adc_seq_pkg::RES_W-1:0] string2_result,
    output logic [adc_seq_pkg::RES_W-1:0] boost_target_level,
    output logic [adc_seq_pkg::RES_W-1:0] normal_window_low,
    output logic [adc_seq_pkg::RES_W-1:0] normal_window_high,
    output logic boost_shutdown,
    output logic boost_gate_drive,
    output logic result_stored
);
    localparam int RW = adc_seq_pkg::RES_W;
    localparam int CW = adc_seq_pkg::TICK_CNT_W;
    localparam logic [17:0] CLK_KHZ_W = 18'(adc_seq_pkg::CLK_KHZ);
    localparam logic [17:0] SYS_INC = 18'(adc_seq_pkg::SYS_OSC_KHZ);
    localparam logic [17:0] BST_SLOW_INC = 18'(adc_seq_pkg::BOOST_OSC_SLOW_KHZ);
    localparam logic [17:0] BST_FAST_INC = 18'(adc_seq_pkg::BOOST_OSC_FAST_KHZ);
    localparam logic [CW-1:0] SLOT_LAST = CW'(adc_seq_pkg::SLOT_TICKS - 1);
    localparam logic [CW-1:0] SETTLE_END = CW'(adc_seq_pkg::SETTLE_TICKS);
    localparam logic [4:0] ODD_LAST = 5'(adc_seq_pkg::ODD_SEQ_LEN - 1);
    localparam logic [15:0] AUX_LAST = 16'(AUX_PERIOD_TICKS - 1);
    localparam logic [2:0] CH_NUM_W = 3'(adc_seq_pkg::CH_NUM);

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_HOLD = 2'b10
    } slot_state_t;

    // Reset release through two flops
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // 4 MHz system tick from a phase accumulator
    logic [17:0] sys_acc_q;
    logic [17:0] sys_sum;
    logic sys_wrap;
    logic sys_tick_q;

    assign sys_sum = sys_acc_q + SYS_INC;
    assign sys_wrap = sys_sum >= CLK_KHZ_W;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sys_acc_q <= 18'h0_0000;
            sys_tick_q <= 1'b0;
        end else begin
            sys_acc_q <= sys_wrap ? (sys_sum - CLK_KHZ_W) : sys_sum;
            sys_tick_q <= sys_wrap;
        end
    end

    // booster reference tick, slow or fast rate
    logic [17:0] bst_acc_q;
    logic [17:0] bst_sum;
    logic [17:0] bst_inc;
    logic bst_wrap;
    logic bst_tick_q;

    assign bst_inc = booster_osc_fast ? BST_FAST_INC : BST_SLOW_INC;
    assign bst_sum = bst_acc_q + bst_inc;
    assign bst_wrap = bst_sum >= CLK_KHZ_W;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bst_acc_q <= 18'h0_0000;
            bst_tick_q <= 1'b0;
        end else begin
            bst_acc_q <= bst_wrap ? (bst_sum - CLK_KHZ_W) : bst_sum;
            bst_tick_q <= bst_wrap;
        end
    end

    // Slot timing and schedule position
    logic [CW-1:0] tick_cnt_q;
    logic slot_odd_q;
    logic [4:0] odd_idx_q;
    logic slot_end;
    logic slot_begin;
    slot_state_t state_q;
    slot_state_t state_d;

    assign slot_end = sys_tick_q && (tick_cnt_q == SLOT_LAST);
    assign slot_begin = sys_tick_q && (tick_cnt_q == {CW{1'b0}});

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= {CW{1'b0}};
            slot_odd_q <= 1'b0;
            odd_idx_q <= 5'h00;
        end else if (slot_end) begin
            tick_cnt_q <= {CW{1'b0}};
            slot_odd_q <= ~slot_odd_q;
            if (slot_odd_q) begin
                odd_idx_q <= (odd_idx_q == ODD_LAST) ? 5'h00 : odd_idx_q + 5'h01;
            end
        end else if (sys_tick_q) begin
            tick_cnt_q <= tick_cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // aux refresh timer arms both aux requests
    logic [15:0] aux_cnt_q;
    logic aux_due;
    logic aux1_pend_q;
    logic aux2_pend_q;

    assign aux_due = sys_tick_q && (aux_cnt_q == AUX_LAST);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aux_cnt_q <= 16'h0000;
        end else if (aux_due) begin
            aux_cnt_q <= 16'h0000;
        end else if (sys_tick_q) begin
            aux_cnt_q <= aux_cnt_q + 16'h0001;
        end
    end

    logic pos_batt;
    logic pos_led1;
    logic pos_led2;
    logic [2:0] pick;
    logic take_aux1;
    logic take_aux2;

    assign pos_batt = odd_idx_q == adc_seq_pkg::POS_BATT;
    assign pos_led1 = (odd_idx_q == adc_seq_pkg::POS_LED1_A)
                   || (odd_idx_q == adc_seq_pkg::POS_LED1_B);
    assign pos_led2 = (odd_idx_q == adc_seq_pkg::POS_LED2_A)
                   || (odd_idx_q == adc_seq_pkg::POS_LED2_B);

    always_comb begin
        pick = adc_seq_pkg::CH_BOOST;
        if (slot_odd_q) begin
            // battery once per 18 odd slots
            if (pos_batt) begin
                pick = adc_seq_pkg::CH_BATT;
            // each string twice per 108 us
            end else if (pos_led1 && string1_active) begin
                pick = adc_seq_pkg::CH_LED1;
            end else if (pos_led2 && string2_active) begin
                pick = adc_seq_pkg::CH_LED2;
            end else if (aux1_pend_q) begin
                pick = adc_seq_pkg::CH_AUX1;
            end else if (aux2_pend_q) begin
                pick = adc_seq_pkg::CH_AUX2;
            end
        end
    end

    assign take_aux1 = slot_begin && (pick == adc_seq_pkg::CH_AUX1);
    assign take_aux2 = slot_begin && (pick == adc_seq_pkg::CH_AUX2);

    // A new period request wins over a slot taking the old one
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aux1_pend_q <= 1'b1;
            aux2_pend_q <= 1'b1;
        end else begin
            aux1_pend_q <= aux_due | (aux1_pend_q & ~take_aux1);
            aux2_pend_q <= aux_due | (aux2_pend_q & ~take_aux2);
        end
    end

    // slot sequence - settle mux, convert, hold
    logic sar_start;
    logic sar_busy;
    logic sar_done;
    logic [RW-1:0] sar_result;

    assign sar_start = (state_q == ST_SETTLE) && sys_tick_q && (tick_cnt_q == SETTLE_END);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_SETTLE: begin
                if (sar_start) begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (sar_done) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                state_d = ST_HOLD;
            end
            default: begin
                state_d = ST_HOLD;
            end
        endcase
        if (slot_end) begin
            state_d = ST_SETTLE;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_SETTLE;
            mux_select <= adc_seq_pkg::CH_BOOST;
        end else begin
            state_q <= state_d;
            if (slot_begin) begin
                mux_select <= pick;
            end
        end
    end

    // one shared converter for all channels
    sar_converter u_sar (
        .clock(clock),
        .rst_n(rst_n),
        .start(sar_start),
        .step_en(sys_tick_q),
        .comp_ge(comp_ge),
        .dac_code(dac_code),
        .result(sar_result),
        .busy(sar_busy),
        .done(sar_done)
    );

    // string result kept if its output went inactive
    logic store_ok;
    logic [RW-1:0] result_q [adc_seq_pkg::CH_NUM];

    always_comb begin
        store_ok = sar_done && (state_q == ST_CONVERT) && sar_busy == 1'b0;
        if (mux_select == adc_seq_pkg::CH_LED1 && !string1_active) begin
            store_ok = 1'b0;
        end
        if (mux_select == adc_seq_pkg::CH_LED2 && !string2_active) begin
            store_ok = 1'b0;
        end
    end

    // whole byte written in one edge per channel
    genvar gi;
    generate
        for (gi = 0; gi < adc_seq_pkg::CH_NUM; gi++) begin : g_mem
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    result_q[gi] <= adc_seq_pkg::RESULT_RST;
                end else if (store_ok && mux_select == 3'(gi)) begin
                    result_q[gi] <= sar_result;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result_stored <= 1'b0;
        end else begin
            result_stored <= store_ok;
        end
    end

    // only codes below six select a result
    logic sel_ok;

    assign sel_ok = measurement_select < CH_NUM_W;

    // readout follows memory, never touches the sequencer
    // refreshed every cycle from the entry a code below six selects
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            measurement_readout_register <= adc_seq_pkg::RESULT_RST;
        end else if (sel_ok) begin
            measurement_readout_register <= result_q[measurement_select];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            boost_result <= adc_seq_pkg::RESULT_RST;
            battery_result <= adc_seq_pkg::RESULT_RST;
            string1_result <= adc_seq_pkg::RESULT_RST;
            string2_result <= adc_seq_pkg::RESULT_RST;
        end else begin
            boost_result <= result_q[adc_seq_pkg::CH_BOOST];
            battery_result <= result_q[adc_seq_pkg::CH_BATT];
            string1_result <= result_q[adc_seq_pkg::CH_LED1];
            string2_result <= result_q[adc_seq_pkg::CH_LED2];
        end
    end

    // range setting selects target, window and shutdown
    logic [RW-1:0] trgt;
    logic [RW-1:0] sd_level;
    logic sd_hit;

    assign trgt = adc_seq_pkg::range_target(boost_range);
    assign sd_level = trgt + adc_seq_pkg::SD_MARGIN_CODE;
    // compare stored boost result with shutdown level
    assign sd_hit = result_q[adc_seq_pkg::CH_BOOST] >= sd_level;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            boost_target_level <= adc_seq_pkg::RESULT_RST;
            normal_window_low <= adc_seq_pkg::RESULT_RST;
            normal_window_high <= adc_seq_pkg::RESULT_RST;
            boost_shutdown <= 1'b0;
        end else begin
            boost_target_level <= trgt;
            normal_window_low <= trgt - adc_seq_pkg::WIN_HALF_CODE;
            normal_window_high <= trgt + adc_seq_pkg::WIN_HALF_CODE;
            boost_shutdown <= sd_hit;
        end
    end

    // gate PWM period is 64 reference ticks
    logic [adc_seq_pkg::PWM_CNT_W-1:0] pwm_cnt_q;
    logic pwm_on;

    assign pwm_on = pwm_cnt_q < boost_duty;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwm_cnt_q <= '0;
        end else if (bst_tick_q) begin
            pwm_cnt_q <= pwm_cnt_q + 1'b1;
        end
    end

    // gate forced low at or above shutdown
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            boost_gate_drive <= 1'b0;
        end else begin
            boost_gate_drive <= pwm_on && !sd_hit;
        end
    end
endmodule
`default_nettype wire

/* tb/seq_monitor.sv */
// Checker on the measurement sequencer top ports.
// Assumes the 125 MHz clock and the default slot timing.
`timescale 1ns/1ps
`default_nettype none
module seq_monitor (
    input wire logic clock,
    input wire logic nrst,
    input wire logic string1_active,
    input wire logic [2:0] measurement_select,
    input wire logic [3:0] boost_range,
    input wire logic [2:0] mux_select,
    input wire logic [7:0] measurement_readout_register,
    input wire logic [7:0] boost_result,
    input wire logic [7:0] battery_result,
    input wire logic [7:0] string1_result,
    input wire logic [7:0] string2_result,
    input wire logic [7:0] boost_target_level,
    input wire logic [7:0] normal_window_low,
    input wire logic [7:0] normal_window_high,
    input wire logic boost_shutdown,
    input wire logic boost_gate_drive,
    input wire logic result_stored
);
    logic [2:0] up_q;
    logic [2:0] mux_q;
    logic [9:0] slot_q;
    logic [15:0] boost_age_q;
    logic [15:0] batt_age_q;
    logic [7:0] sel_res;
    assign sel_res = measurement_select == 3'h0 ? boost_result :
        measurement_select == 3'h1 ? battery_result :
        measurement_select == 3'h2 ? string1_result : string2_result;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            up_q <= 3'h0;
            mux_q <= 3'h0;
            slot_q <= 10'h000;
            boost_age_q <= 16'h0000;
            batt_age_q <= 16'h0000;
        end else begin
            up_q <= up_q == 3'h7 ? up_q : up_q + 3'h1;
            mux_q <= mux_select;
            slot_q <= mux_select != mux_q ? 10'h000 : (&slot_q ? slot_q : slot_q + 10'h001);
            boost_age_q <= result_stored && mux_select == 3'h0 ? 16'h0000 : boost_age_q + 16'h0001;
            batt_age_q <= result_stored && mux_select == 3'h1 ? 16'h0000 : batt_age_q + 16'h0001;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    readout_follows_a: assert property ((up_q == 3'h7 && measurement_select < 3'h4 &&
        $stable(measurement_select) && $stable(sel_res)) [*3]
        |-> measurement_readout_register == sel_res) else $error("readout differs from result");
    gate_cut_a: assert property (boost_shutdown && $past(boost_shutdown)
        |-> !boost_gate_drive) else $error("gate on during shutdown");
    shutdown_level_a: assert property ((up_q == 3'h7 && $stable(boost_result) &&
        $stable(boost_range)) [*4] |-> boost_shutdown == ({1'b0, boost_result} >=
        {1'b0, boost_target_level} + 9'(adc_seq_pkg::SD_MARGIN_CODE)))
        else $error("shutdown flag wrong");
    range_table_a: assert property ((up_q == 3'h7 && $stable(boost_range)) [*3]
        |-> boost_target_level == 8'h30 + {1'b0, boost_range, 3'h0} &&
        normal_window_low == boost_target_level - 8'h10 &&
        normal_window_high == boost_target_level + 8'h10) else $error("range table wrong");
    mux_slot_a: assert property ($changed(mux_select) |-> slot_q >= 10'd370)
        else $error("slot too short");
    boost_fresh_a: assert property (boost_age_q <= 16'd2125)
        else $error("boost result stale");
    batt_fresh_a: assert property (batt_age_q <= 16'd13900)
        else $error("battery result stale");
    string_hold_a: assert property (!string1_active && !$past(string1_active, 4)
        |-> $stable(string1_result)) else $error("inactive string result changed");
    stored_pulse_a: assert property (result_stored |=> !result_stored)
        else $error("store pulse too long");
endmodule
bind adc_measurement_sequencer seq_monitor seq_monitor_i (.clock, .nrst, .string1_active,
    .measurement_select, .boost_range, .mux_select, .measurement_readout_register,
    .boost_result, .battery_result, .string1_result, .string2_result, .boost_target_level,
    .normal_window_low, .normal_window_high, .boost_shutdown, .boost_gate_drive,
    .result_stored);
`default_nettype wire

/* tb/analog_front_model.sv */
// Analog mux, channel levels and comparator facing the converter.
// Assumes the testbench sets one level code per channel.
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
    input wire logic [2:0] mux_select,
    input wire logic [7:0] dac_code,
    input wire logic [7:0] level [6],
    output logic comp_ge
);
    assign comp_ge = mux_select < 3'h6 && level[mux_select] >= dac_code;
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the measurement sequencer.
// Assumes the analog model answers the converter at once.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock, nrst, comp_ge, string1_active, string2_active, osc_fast, gate, sd, stored;
    logic [2:0] sel, mux;
    logic [3:0] rng;
    logic [5:0] duty;
    logic [7:0] lvl [6];
    logic [7:0] dac, rd, b_res, v_res, s1_res, s2_res, trg, wl, wh;
    int n_mismatch, samples_checked, n, hi, ris;
    adc_measurement_sequencer #(.AUX_PERIOD_TICKS(100)) adc_measurement_sequencer_i (
        .clock(clock), .nrst(nrst), .comp_ge(comp_ge), .string1_active(string1_active),
        .string2_active(string2_active), .measurement_select(sel), .boost_range(rng),
        .booster_osc_fast(osc_fast), .boost_duty(duty), .mux_select(mux), .dac_code(dac),
        .measurement_readout_register(rd), .boost_result(b_res), .battery_result(v_res),
        .string1_result(s1_res), .string2_result(s2_res), .boost_target_level(trg),
        .normal_window_low(wl), .normal_window_high(wh), .boost_shutdown(sd),
        .boost_gate_drive(gate), .result_stored(stored));
    analog_front_model analog_front_model_i (.mux_select(mux), .dac_code(dac), .level(lvl),
        .comp_ge(comp_ge));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_in(input string what, input int lo, input int hi_v, input int got);
        samples_checked++;
        if (got < lo || got > hi_v) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi_v, got);
        end
    endtask
    // Clocks to the next store of channel ch
    task automatic wait_store(input logic [2:0] ch);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (!(stored === 1'b1 && mux === ch) && n < 20000);
        if (n >= 20000) begin
            n_mismatch++;
            $display("CHECK FAILED store of channel %0d expected within 20000 seen none", ch);
            end_sim();
        end
    endtask
    task automatic gate_count;
        logic prev;
        hi = 0;
        ris = 0;
        prev = gate;
        repeat (1456) begin
            @(negedge clock);
            hi += int'(gate === 1'b1);
            ris += int'(gate === 1'b1 && prev !== 1'b1);
            prev = gate;
        end
    endtask
    task automatic t_period;
        wait_store(3'h0);
        wait_store(3'h0);
        chk_in("boost interval", 1, 2125, n);
        wait_store(3'h1);
        wait_store(3'h1);
        chk_in("battery interval", 13499, 13501, n);
        wait_store(3'h2);
        wait_store(3'h2);
        chk_in("string interval", 6499, 7001, n);
    endtask
    task automatic t_readout;
        for (int i = 0; i < 6; i++) begin
            sel = 3'(i);
            repeat (3) @(negedge clock);
            chk("readout", lvl[i], rd);
        end
        chk("boost result", lvl[0], b_res);
        chk("battery result", lvl[1], v_res);
        chk("string1 result", lvl[2], s1_res);
        chk("string2 result", lvl[3], s2_res);
        chk("shutdown flag", 8'h01, {7'h00, sd});
    endtask
    task automatic t_poll;
        sel = 3'h0;
        for (int i = 0; i < 2; i++) begin
            lvl[0] = 8'h35 + 8'(i);
            wait_store(3'h0);
            wait_store(3'h0);
            repeat (4) @(negedge clock);
            chk("polled readout", 8'h35 + 8'(i), rd);
        end
    endtask
    task automatic t_hold;
        string1_active = 1'b0;
        sel = 3'h2;
        lvl[2] = 8'h5A;
        repeat (8000) @(negedge clock);
        chk("held string1", 8'h80, s1_res);
        chk("held readout", 8'h80, rd);
        string1_active = 1'b1;
        wait_store(3'h2);
        repeat (4) @(negedge clock);
        chk("fresh string1", 8'h5A, s1_res);
    endtask
    task automatic t_aux;
        lvl[4] = 8'h3C;
        lvl[5] = 8'hC3;
        repeat (7000) @(negedge clock);
        sel = 3'h4;
        repeat (3) @(negedge clock);
        chk("aux1 readout", 8'h3C, rd);
        sel = 3'h5;
        repeat (3) @(negedge clock);
        chk("aux2 readout", 8'hC3, rd);
    endtask
    task automatic t_range_gate;
        for (int r = 0; r < 16; r++) begin
            rng = 4'(r);
            repeat (3) @(negedge clock);
            chk("target", 8'h30 + 8'(r * 8), trg);
            chk("window low", 8'h20 + 8'(r * 8), wl);
            chk("window high", 8'h40 + 8'(r * 8), wh);
        end
        // window low 0x88 above both strings
        rng = 4'hD;
        for (int i = 0; i < 2; i++) begin
            lvl[0] = i == 0 ? 8'hB0 : 8'hAF;
            wait_store(3'h0);
            wait_store(3'h0);
            repeat (4) @(negedge clock);
            chk("shutdown at level", i == 0 ? 8'h01 : 8'h00, {7'h00, sd});
            gate_count();
            chk_in("gate high clocks", i == 0 ? 0 : 690, i == 0 ? 0 : 770, hi);
        end
        chk_in("slow periods", 2, 3, ris);
        osc_fast = 1'b1;
        gate_count();
        chk_in("fast periods", 4, 5, ris);
        chk_in("fast high clocks", 690, 770, hi);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clock);
        n_mismatch++;
        $display("watchdog expired");
        end_sim();
    end
    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        nrst = 1'b0;
        string1_active = 1'b1;
        string2_active = 1'b1;
        osc_fast = 1'b0;
        sel = 3'h0;
        rng = 4'h0;
        duty = 6'h20;
        lvl = '{8'hFF, 8'h00, 8'h80, 8'h7F, 8'h01, 8'hAA};
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        t_period();
        t_readout();
        t_poll();
        t_hold();
        t_aux();
        t_range_gate();
        end_sim();
    end
endmodule
`default_nettype wire
